// file: sct_charger_limit_regs.sv
/*
  Serial-bus slave front end of a charger: settings registers, input
  limit quantisation and the two charging safety timers.
  Assumes the host drives scl (no clock stretching), a pull-up on the
  data wire, and a free-running 200 MHz clk.
*/
// How it works
// - Input limit word, 2 mA per step
// - Input limit sits at code 0x3F, word write
// - Only bits 7 to 12 drive the DAC
// - DAC weights 256 mA up to 8192 mA
// - Requests above 11.004 A clamp to 11.004 A
// - Requests under 256 mA give zero
// - Input limit starts at 256 mA
// - Input limit word reads back
// - No setpoint write for 175 s stops charging
// - Clock line low over 25 ms stops charging
// - Only a setpoint write resumes charging
// - Every access moves exactly two bytes
// - Low byte first, then high byte
// - Write: address, code, low, high, all acked
// - Charge current sits at code 0x14
// - New settings apply only at Stop
// - One register per write transaction
// - Five registers can be read
// - Read: low acked by host, high not
// - One register per read transaction
// - Charge voltage sits at code 0x15
// - Voltage and current reset to zero, charger off
`timescale 1ns/100ps
`include "sct_map.svh"

module sct_charger_limit_regs #(
  parameter logic [15:0] MFR_ID = 16'hA5A5, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h5A01, // Arbitrary value
  parameter logic [35:0] WDOG_CYC =
    36'(`SCT_WDOG_S * `SCT_CLK_HZ),
  parameter logic [22:0] SCL_LOW_CYC =
    23'(`SCT_SCL_LOW_MS * `SCT_CLK_HZ / 64'd1000)
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Bus pins; scl also clocks the bit capture
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Settings toward the regulator
  output logic [15:0] charge_voltage_setting,
  output logic [15:0] charge_current_setting,
  output logic [5:0] input_limit_dac_bits,
  output logic [15:0] input_limit_eff,
  // Charger state
  output logic charge_en,
  output logic charge_timeout
);

  // Effective input limit in 2 mA steps
  function automatic logic [15:0] il_eff(input logic [15:0] raw);
    logic [15:0] q;
    q = {3'h0, raw[12:7], 7'h00};
    if (raw > `SCT_IL_MAX) begin
      q = `SCT_IL_MAX;
    end
    return q; // Under 256 mA the kept bits are zero
  endfunction

  // Word returned for a register code
  function automatic logic [15:0] rd_sel(input logic [7:0] code,
                                         input sct_pkg::sct_regs_t r);
    logic [15:0] w;
    w = 16'h0000;
    case (code)
      `SCT_REG_CC: w = r.cc;
      `SCT_REG_CV: w = r.cv;
      `SCT_REG_IL: w = r.il;
      `SCT_REG_MFR: w = MFR_ID;
      `SCT_REG_DEV: w = DEV_ID;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  logic lnk_bit_q;
  logic [1:0] scl_sy_q;
  logic [1:0] sda_sy_q;
  logic [1:0] bit_sy_q;
  logic scl_p_q;
  logic sda_p_q;
  logic [1:0] rise_dly_q;
  sct_pkg::sct_bus_ev_t ev;
  logic sbit;
  sct_pkg::sct_state_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic [7:0] lo_q;
  logic [15:0] wr_q;
  logic wr_pend_q;
  logic oe_q;
  logic sda_o_q;
  sct_pkg::sct_regs_t regs_q;
  logic [15:0] rd_w;
  logic commit;
  logic cw_wr;
  logic [35:0] wdog_q;
  logic [22:0] lo_cnt_q;
  logic wdog_hit;
  logic scl_hit;
  logic tout_q;
  logic en_q;
  logic [15:0] eff_q, eff_d;
  logic [5:0] dac_q;

  // Link side: capture the data line on each rising clock edge.
  // Data only; the clk side reads it once the edge is known.
  always_ff @(posedge scl) begin
    lnk_bit_q <= sda_i;
  end

  // Two-flop synchronisers plus one stage for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      bit_sy_q <= 2'h0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      rise_dly_q <= 2'h0;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl};
      sda_sy_q <= {sda_sy_q[0], sda_i};
      bit_sy_q <= {bit_sy_q[0], lnk_bit_q};
      scl_p_q <= scl_sy_q[1];
      sda_p_q <= sda_sy_q[1];
      rise_dly_q <= {rise_dly_q[0], scl_sy_q[1] & ~scl_p_q};
    end
  end

  // Rise is delayed so the captured bit has surely crossed
  always_comb begin
    ev.rise = rise_dly_q[1];
    ev.fall = ~scl_sy_q[1] & scl_p_q;
    ev.start = scl_sy_q[1] & scl_p_q & ~sda_sy_q[1] & sda_p_q;
    ev.stop = scl_sy_q[1] & scl_p_q & sda_sy_q[1] & ~sda_p_q;
    sbit = bit_sy_q[1];
  end

  assign rd_w = rd_sel(ptr_q, regs_q);

  // Byte sequencer: receive, acknowledge and transmit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= sct_pkg::ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      lo_q <= 8'h00;
      wr_q <= 16'h0000;
      wr_pend_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (ev.start) begin
      st_q <= sct_pkg::ST_DEV;
      bit_q <= 4'hF; // Start's own clock fall wraps this to zero
      oe_q <= 1'b0;
      wr_pend_q <= 1'b0; // A write without Stop is dropped
    end else if (ev.stop) begin
      st_q <= sct_pkg::ST_IDLE;
      oe_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else if (st_q != sct_pkg::ST_IDLE) begin
      if (ev.rise) begin
        if (bit_q < `SCT_BIT_ACK) begin
          sh_q <= {sh_q[6:0], sbit};
        end else if (st_q == sct_pkg::ST_RLO && sbit) begin
          st_q <= sct_pkg::ST_IGN; // Host gave up after low byte
        end
      end
      if (ev.fall) begin
        if (bit_q == `SCT_BIT_LAST) begin
          bit_q <= `SCT_BIT_ACK;
          case (st_q)
            sct_pkg::ST_DEV: begin
              oe_q <= (sh_q[7:1] == `SCT_SLAVE_ADDR);
              if (sh_q[7:1] != `SCT_SLAVE_ADDR) begin
                st_q <= sct_pkg::ST_IGN;
              end
            end
            sct_pkg::ST_REG: begin
              oe_q <= 1'b1;
              ptr_q <= sh_q;
            end
            sct_pkg::ST_DLO: begin
              oe_q <= 1'b1;
              lo_q <= sh_q;
            end
            sct_pkg::ST_DHI: begin
              oe_q <= 1'b1;
              wr_q <= {sh_q, lo_q};
              wr_pend_q <= 1'b1;
            end
            default: oe_q <= 1'b0; // Release for the host's ack
          endcase
        end else if (bit_q == `SCT_BIT_ACK) begin
          bit_q <= 4'h0;
          oe_q <= 1'b0;
          case (st_q)
            sct_pkg::ST_DEV: begin
              if (sh_q[0]) begin
                st_q <= sct_pkg::ST_RLO;
                oe_q <= ~rd_w[7];
                tx_q <= {rd_w[6:0], 1'b0};
              end else begin
                st_q <= sct_pkg::ST_REG;
              end
            end
            sct_pkg::ST_REG: st_q <= sct_pkg::ST_DLO;
            sct_pkg::ST_DLO: st_q <= sct_pkg::ST_DHI;
            // Further bytes go unacknowledged
            sct_pkg::ST_DHI: st_q <= sct_pkg::ST_IGN;
            sct_pkg::ST_RLO: begin
              st_q <= sct_pkg::ST_RHI;
              oe_q <= ~rd_w[15];
              tx_q <= {rd_w[14:8], 1'b0};
            end
            sct_pkg::ST_RHI: st_q <= sct_pkg::ST_IGN;
            default: st_q <= sct_pkg::ST_IGN;
          endcase
        end else begin
          bit_q <= bit_q + 4'h1;
          if (st_q == sct_pkg::ST_RLO || st_q == sct_pkg::ST_RHI) begin
            oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // The pin only ever pulls low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  // A complete write lands only at Stop
  assign commit = ev.stop & wr_pend_q & (st_q == sct_pkg::ST_IGN);
  assign cw_wr = commit &
    (ptr_q == `SCT_REG_CC || ptr_q == `SCT_REG_CV);

  // Register store; unknown codes fall through untouched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regs_q.cv <= 16'h0000;
      regs_q.cc <= 16'h0000;
      regs_q.il <= `SCT_IL_POR;
    end else if (commit) begin
      case (ptr_q)
        `SCT_REG_CC: regs_q.cc <= wr_q;
        `SCT_REG_CV: regs_q.cv <= wr_q;
        `SCT_REG_IL: regs_q.il <= wr_q;
        default: regs_q <= regs_q;
      endcase
    end
  end

  // Setpoint watchdog; saturates so the hit is one pulse
  assign wdog_hit = (wdog_q == WDOG_CYC - 36'h1);
  always_ff @(posedge clk) begin
    if (sys_rst || cw_wr) begin
      wdog_q <= 36'h0;
    end else if (wdog_q != WDOG_CYC) begin
      wdog_q <= wdog_q + 36'h1;
    end
  end

  // Clock-low timer, cleared by any high level
  assign scl_hit = (lo_cnt_q == SCL_LOW_CYC - 23'h1);
  always_ff @(posedge clk) begin
    if (sys_rst || scl_sy_q[1]) begin
      lo_cnt_q <= 23'h0;
    end else if (lo_cnt_q != SCL_LOW_CYC) begin
      lo_cnt_q <= lo_cnt_q + 23'h1;
    end
  end

  // Timeout latch: a new hit wins over a same-cycle resume
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tout_q <= 1'b0;
    end else if (wdog_hit || scl_hit) begin
      tout_q <= 1'b1;
    end else if (cw_wr) begin
      tout_q <= 1'b0;
    end
  end

  // Charger runs only with cv bits 14:4 and cc bits 12:7 both nonzero and no timeout
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= (|regs_q.cv[14:4]) & (|regs_q.cc[12:7]) & ~tout_q;
    end
  end

  // Input limit DAC drive, quantised and clamped
  assign eff_d = il_eff(regs_q.il);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eff_q <= `SCT_IL_POR;
      dac_q <= 6'h01;
    end else begin
      eff_q <= eff_d;
      dac_q <= eff_d[12:7];
    end
  end

  assign sda_o = sda_o_q;
  assign sda_oe = oe_q;
  assign charge_voltage_setting = regs_q.cv;
  assign charge_current_setting = regs_q.cc;
  assign input_limit_dac_bits = dac_q;
  assign input_limit_eff = eff_q;
  assign charge_en = en_q;
  assign charge_timeout = tout_q;

  // Checks
  sequence s_data_byte_end;
    ev.fall && bit_q == `SCT_BIT_LAST &&
      (st_q == sct_pkg::ST_REG || st_q == sct_pkg::ST_DLO ||
       st_q == sct_pkg::ST_DHI);
  endsequence

  sequence s_setpoint_write;
    cw_wr ##1 1'b1;
  endsequence

  chk_lim_por: assert property (
    @(posedge clk) $past(sys_rst) |-> eff_q == `SCT_IL_POR)
    else $error("input limit not 256 mA after reset");

  chk_lim_clamp: assert property (
    @(posedge clk) disable iff (sys_rst)
    regs_q.il > `SCT_IL_MAX |=> eff_q == `SCT_IL_MAX)
    else $error("input limit not clamped");

  chk_lim_quant: assert property (
    @(posedge clk) disable iff (sys_rst)
    regs_q.il <= `SCT_IL_MAX |=>
      eff_q == {3'h0, $past(regs_q.il[12:7]), 7'h00})
    else $error("input limit quantised wrongly");

  chk_lim_low: assert property (
    @(posedge clk) disable iff (sys_rst)
    regs_q.il[15:7] == 9'h000 |=> eff_q == 16'h0000 && dac_q == 6'h00)
    else $error("small input limit not zero");

  chk_commit_stop: assert property (
    @(posedge clk) disable iff (sys_rst)
    $changed(regs_q) |-> $past(ev.stop) && $past(wr_pend_q))
    else $error("register changed without Stop");

  chk_data_ack: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_data_byte_end |=> sda_oe && bit_q == `SCT_BIT_ACK)
    else $error("data byte not acknowledged");

  chk_wdog_tout: assert property (
    @(posedge clk) disable iff (sys_rst)
    wdog_hit |=> charge_timeout ##1 !charge_en)
    else $error("watchdog did not stop charging");

  chk_scl_tout: assert property (
    @(posedge clk) disable iff (sys_rst)
    scl_hit |=> charge_timeout ##1 !charge_en)
    else $error("clock-low timeout did not stop charging");

  chk_resume_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(tout_q) |-> $past(cw_wr))
    else $error("timeout cleared without a setpoint write");

  chk_charge_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_setpoint_write |=> charge_en ==
      ((|regs_q.cv[14:4]) && (|regs_q.cc[12:7]) && !$past(tout_q)))
    else $error("charge enable wrong after setpoint write");

endmodule

// file: sct_charger_limit_regs_test.sv
/*
  Self-checking bench for the charger settings slave.
  Assumes sct_host_model drives the bus; the data wire pull-up is here.
*/
`timescale 1ns/100ps
`include "sct_map.svh"

module sct_charger_limit_regs_test;
  localparam logic [15:0] MFR = 16'h3C3C; // Arbitrary value
  localparam logic [15:0] DEV = 16'h0C02; // Arbitrary value
  logic clk, sys_rst, scl, sda_pull, sda, sda_o, sda_oe, a;
  logic charge_en, charge_timeout;
  logic [15:0] cv, cc, eff, exp_eff, w, rdv;
  logic [7:0] q;
  logic [5:0] dac;
  logic [31:0] rnd, errors, tests_run, cycles;
  logic [15:0] corner [7] = '{16'h0000, 16'h007F, 16'h0080, 16'h157E,
    16'h157F, 16'hFFFF, 16'h41A0};
  logic [7:0] rcode [4] = '{`SCT_REG_CC, `SCT_REG_CV, `SCT_REG_MFR,
    `SCT_REG_DEV};
  logic [15:0] rexp [4] = '{16'h0800, 16'h3070, MFR, DEV};

  // Open-drain data wire with pull-up
  assign sda = !((sda_oe && !sda_o) || sda_pull);

  sct_host_model host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  // Short timer counts keep the run brief
  sct_charger_limit_regs #(.MFR_ID(MFR), .DEV_ID(DEV),
    .WDOG_CYC(36'h9C40), .SCL_LOW_CYC(23'hC8)) DUT (
    .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .charge_voltage_setting(cv),
    .charge_current_setting(cc), .input_limit_dac_bits(dac),
    .input_limit_eff(eff), .charge_en(charge_en),
    .charge_timeout(charge_timeout));

  // Stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Clamp at 11.004 A, bits under 256 mA dropped
  function automatic logic [15:0] lim(input logic [15:0] r);
    return (r > 16'h157E) ? 16'h157E : {3'h0, r[12:7], 7'h00};
  endfunction

  task automatic chk16(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, g);
    chk16(n, {15'h0, e}, {15'h0, g});
  endtask

  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Word write; extra adds a fifth byte that must be refused
  task automatic wr(input logic [7:0] code, input logic [15:0] d,
                    input logic extra);
    logic [7:0] b [5];
    logic [7:0] bq;
    logic ba;
    b = '{{`SCT_SLAVE_ADDR, 1'b0}, code, d[7:0], d[15:8], 8'h5A};
    host.start_c();
    for (int i = 0; i < (extra ? 5 : 4); i++) begin
      host.xfer(b[i], 1'b1, bq, ba);
      chk1("write ack", i > 3, ba);
    end
    chk16("limit before stop", exp_eff, eff);
    host.stop_c();
    repeat (8) @(posedge clk);
    if (code == `SCT_REG_IL) exp_eff = lim(d);
    chk16("limit after stop", exp_eff, eff);
  endtask

  // Select code, Stop, then read two bytes
  task automatic rd(input logic [7:0] code, output logic [15:0] d);
    logic [7:0] bq;
    logic ba;
    host.start_c();
    host.xfer({`SCT_SLAVE_ADDR, 1'b0}, 1'b1, bq, ba);
    host.xfer(code, 1'b1, bq, ba);
    host.stop_c();
    host.start_c();
    host.xfer({`SCT_SLAVE_ADDR, 1'b1}, 1'b1, bq, ba);
    chk1("read ack", 1'b0, ba);
    host.xfer(8'hFF, 1'b0, d[7:0], ba);
    host.xfer(8'hFF, 1'b1, d[15:8], ba);
    host.stop_c();
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 32'h1;
    if (cycles == 32'h15F90) begin
      errors = errors + 32'h1;
      stop_test();
    end
  end

  initial begin
    sys_rst = 1'b1;
    errors = 32'h0;
    tests_run = 32'h0;
    cycles = 32'h0;
    rnd = 32'hAB30;
    exp_eff = 16'h0080;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk16("limit at reset", 16'h0080, eff);
    chk16("dac at reset", 16'h0001, {10'h0, dac});
    chk16("voltage at reset", 16'h0000, cv);
    chk16("current at reset", 16'h0000, cc);
    chk1("off at reset", 1'b0, charge_en);
    $display("test reset done");
    // Setpoints; charging needs both
    wr(`SCT_REG_CV, 16'h3070, 1'b0);
    chk1("off without current", 1'b0, charge_en);
    wr(`SCT_REG_CC, 16'h0800, 1'b1);
    chk16("current word", 16'h0800, cc);
    chk1("charging on", 1'b1, charge_en);
    $display("test setpoints done");
    // Limit corners, then random words
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      w = (i < 7) ? corner[i] : rnd[15:0];
      wr(`SCT_REG_IL, w, 1'b0);
      chk16("dac bits", {10'h0, exp_eff[12:7]}, {10'h0, dac});
      rd(`SCT_REG_IL, rdv);
      chk16("limit readback", w, rdv);
    end
    $display("test limit done");
    for (int i = 0; i < 4; i++) begin
      rd(rcode[i], rdv);
      chk16("register read", rexp[i], rdv);
    end
    wr(8'h20, 16'hBEEF, 1'b0);
    rd(8'h20, rdv);
    chk16("unknown reads", 16'h0000, rdv);
    chk16("current kept", 16'h0800, cc);
    host.start_c();
    host.xfer(8'h14, 1'b1, q, a);
    chk1("foreign address ack", 1'b1, a);
    host.stop_c();
    $display("test reads done");
    // Clock line held low: 200 cycles allowed
    host.start_c();
    #800;
    chk1("before stall limit", 1'b1, charge_en);
    #1200;
    chk1("stall timeout", 1'b1, charge_timeout);
    chk1("stall stops", 1'b0, charge_en);
    host.stop_c();
    wr(`SCT_REG_IL, 16'h0100, 1'b0);
    chk1("limit no resume", 1'b0, charge_en);
    wr(`SCT_REG_CC, 16'h0800, 1'b0);
    chk1("current resumes", 1'b1, charge_en);
    $display("test stall done");
    // Setpoint watchdog: 40000 cycles
    repeat (38000) @(posedge clk);
    chk1("before watchdog", 1'b1, charge_en);
    repeat (3000) @(posedge clk);
    chk1("watchdog timeout", 1'b1, charge_timeout);
    chk1("watchdog stops", 1'b0, charge_en);
    wr(`SCT_REG_CV, 16'h3070, 1'b0);
    chk1("voltage resumes", 1'b1, charge_en);
    $display("test watchdog done");
    stop_test();
  end
endmodule

// file: sct_host_model.sv
/*
  Host master model for the charger settings bus.
  Assumes the bench resolves the pulled-up data wire.
*/
`timescale 1ns/100ps

module sct_host_model (
  // Bus wires
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // Clock stands high between frames, 80 ns period inside them
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Data moves 10 ns after scl falls, so no false Start or Stop is seen
  task automatic bit_x(input logic b, output logic r);
    #10 sda_pull = !b;
    #30 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
  endtask

  // Start from idle; leaves scl low
  task automatic start_c();
    // Off the clk grid, so the two clocks never share an edge
    #1.3 sda_pull = 1'b0;
    #40 sda_pull = 1'b1;
    #40 scl = 1'b0;
  endtask

  // Stop, then the wire is released to the pull-up
  task automatic stop_c();
    #10 sda_pull = 1'b1;
    #30 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #40;
  endtask

  // Byte MSB first, then the level sent on the ninth clock
  task automatic xfer(input logic [7:0] d, input logic nine,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(nine, ack);
  endtask
endmodule

// file: sct_map.svh
/*
  Register codes, field positions, reset values and timing figures
  for the charger settings slave. Assumes a 200 MHz system clock.
*/
`ifndef SCT_MAP_SVH
`define SCT_MAP_SVH

// Register codes on the bus
`define SCT_REG_CC 8'h14
`define SCT_REG_CV 8'h15
`define SCT_REG_IL 8'h3F
`define SCT_REG_MFR 8'hFE
`define SCT_REG_DEV 8'hFF

// Seven-bit slave address
`define SCT_SLAVE_ADDR 7'h09

// Input limit in 2 mA steps: 256 mA at reset, 11.004 A ceiling
`define SCT_IL_POR 16'h0080
`define SCT_IL_MAX 16'h157E

// Byte handling
`define SCT_BIT_ACK 4'h8
`define SCT_BIT_LAST 4'h7

// Timing figures as printed, and the clock rate
`define SCT_CLK_HZ 64'd200000000
`define SCT_WDOG_S 64'd175
`define SCT_SCL_LOW_MS 64'd25

`endif

// file: sct_pkg.sv
/*
  Types for the charger settings slave.
  Assumes sct_map.svh supplies the numeric constants.
*/
package sct_pkg;

  // Byte phase of a transaction, Gray coded along the write path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV  = 3'h1,
    ST_REG  = 3'h3,
    ST_DLO  = 3'h2,
    ST_DHI  = 3'h6,
    ST_RLO  = 3'h7,
    ST_RHI  = 3'h5,
    ST_IGN  = 3'h4
  } sct_state_t;

  // Bus conditions seen in the system clock domain
  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } sct_bus_ev_t;

  // Stored register words
  typedef struct packed {
    logic [15:0] cv;
    logic [15:0] cc;
    logic [15:0] il;
  } sct_regs_t;

endpackage
